//--- rtl/rac_params.svh
// timing counts, register offsets and field positions of the rotary angle core
// assumes a 100 MHz ref_clk; included by bare name from every design module
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH
`define RAC_CLK_NS 10
`define RAC_SAMPLE_NS 222
`define RAC_SAMPLE_CYCLES (`RAC_SAMPLE_NS / `RAC_CLK_NS)
`define RAC_PON_MS 10
`define RAC_PON_CYCLES (`RAC_PON_MS * 1000000 / `RAC_CLK_NS)
`define RAC_TDELAY_NS 100000
`define RAC_COMP_GAIN (`RAC_TDELAY_NS / `RAC_SAMPLE_NS)
`define RAC_STEP_CYCLES 2
`define RAC_PWM_HEAD 16
`define RAC_PWM_TAIL 8
`define RAC_PWM_PERIOD (`RAC_PWM_HEAD + 4096 + `RAC_PWM_TAIL)
`define RAC_AGC_TARGET 14'h0c00
`define RAC_AGC_HYST 14'h0080
`define RAC_AGC_RESET 8'h80
`define RAC_HALF_TURN 14'h2000
`define RAC_CORDIC_LAST 4'hd
`define RAC_FRAME_BITS 5'h10
`define RAC_FRM_RW 14
`define RAC_ADDR_NOP 14'h0000
`define RAC_ADDR_ERRORS 14'h0001
`define RAC_ADDR_DIAG 14'h3ffc
`define RAC_ADDR_MAGN 14'h3ffd
`define RAC_ADDR_ANGLE_RAW 14'h3ffe
`define RAC_ADDR_ANGLE_COMP 14'h3fff
`define RAC_ERR_PARITY 2
`define RAC_ERR_INVALID 1
`define RAC_ERR_FRAME 0
`endif

//--- rtl/rac_pkg.sv
// types shared by the rotary angle core modules
// assumes rac_params.svh supplies the numeric constants
package rac_pkg;
  typedef logic [13:0] rac_angle_t; // one turn is 2^14 counts
  typedef enum logic [1:0] {
    RAC_CD_IDLE = 2'b00,
    RAC_CD_RUN = 2'b01,
    RAC_CD_DONE = 2'b11
  } rac_cd_state_t; // vectoring engine states
  typedef enum logic {
    RAC_LINK_CMD = 1'b0,
    RAC_LINK_DATA = 1'b1
  } rac_link_t; // which frame the serial link expects next
endpackage

//--- rtl/rac_cordic.sv
// iterative vectoring engine: turns one x/y sample into angle and magnitude
// assumes samples on ref_clk; start is ignored while a run is in progress
`timescale 1ns/100ps
`include "rac_params.svh"
module rac_cordic
  import rac_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic start, // one-cycle request to convert
  input wire logic signed [11:0] sensX, // cosine channel sample
  input wire logic signed [11:0] sensY, // sine channel sample
  output logic done, // one-cycle pulse, results new
  output rac_angle_t angle, // angle, 2^14 per turn
  output rac_angle_t magn // field magnitude, gain 1.647
);
  // arctangent of 2^-i in angle counts
  function automatic rac_angle_t atanStep(input logic [3:0] i);
    unique case (i)
      4'h0: atanStep = 14'h0800;
      4'h1: atanStep = 14'h04b9;
      4'h2: atanStep = 14'h027f;
      4'h3: atanStep = 14'h0144;
      4'h4: atanStep = 14'h00a3;
      4'h5: atanStep = 14'h0051;
      4'h6: atanStep = 14'h0029;
      4'h7: atanStep = 14'h0014;
      4'h8: atanStep = 14'h000a;
      4'h9: atanStep = 14'h0005;
      4'ha: atanStep = 14'h0003;
      4'hb: atanStep = 14'h0001;
      4'hc: atanStep = 14'h0001;
      default: atanStep = 14'h0000;
    endcase
  endfunction

  rac_cd_state_t stateQ; // engine state
  logic signed [15:0] xQ; // working x
  logic signed [15:0] yQ; // working y
  rac_angle_t zQ; // accumulated angle
  logic [3:0] iterQ; // iteration index
  wire logic signed [15:0] xShift = xQ >>> iterQ; // scaled x
  wire logic signed [15:0] yShift = yQ >>> iterQ; // scaled y
  wire logic turnCw = ~yQ[15]; // vector above axis: rotate clockwise
  wire rac_angle_t zStep = atanStep(iterQ); // this iteration's angle
  wire logic signed [15:0] xWide = 16'(sensX); // sign-extended x
  wire logic signed [15:0] yWide = 16'(sensY); // sign-extended y
  wire logic leftHalf = sensX[11]; // pre-rotate by half a turn
  wire logic magnOver = |xQ[15:14]; // magnitude above 14 bits

  // one pre-rotation, fourteen micro-rotations, one result cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stateQ <= RAC_CD_IDLE;
      xQ <= 16'h0000;
      yQ <= 16'h0000;
      zQ <= 14'h0000;
      iterQ <= 4'h0;
      done <= 1'b0;
      angle <= 14'h0000;
      magn <= 14'h0000;
    end else begin
      done <= 1'b0;
      unique case (stateQ)
        RAC_CD_IDLE: if (start) begin
          xQ <= leftHalf ? -xWide : xWide;
          yQ <= leftHalf ? -yWide : yWide;
          zQ <= leftHalf ? `RAC_HALF_TURN : 14'h0000;
          iterQ <= 4'h0;
          stateQ <= RAC_CD_RUN;
        end
        RAC_CD_RUN: begin
          xQ <= turnCw ? xQ + yShift : xQ - yShift;
          yQ <= turnCw ? yQ - xShift : yQ + xShift;
          zQ <= turnCw ? zQ + zStep : zQ - zStep;
          iterQ <= iterQ + 4'h1;
          if (iterQ == `RAC_CORDIC_LAST) stateQ <= RAC_CD_DONE;
        end
        RAC_CD_DONE: begin
          angle <= zQ;
          magn <= magnOver ? 14'h3fff : xQ[13:0];
          done <= 1'b1;
          stateQ <= RAC_CD_IDLE;
        end
        default: stateQ <= RAC_CD_IDLE; // illegal code recovers
      endcase
    end
  end
endmodule

//--- rtl/rac_spi_slave.sv
// mode-1 serial slave sampled by ref_clk: 16-bit frames, msb first
// assumes pins are asynchronous and the serial clock is at most 10 MHz
`timescale 1ns/100ps
`include "rac_params.svh"
module rac_spi_slave
  import rac_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic spiSclk, // serial clock pin from master
  input wire logic chipSelectN, // select pin, active low
  input wire logic spiMosi, // master-out data pin
  output logic spiMisoOut, // slave-out data
  output logic spiMisoOe, // high while slave-out is driven
  input wire logic [15:0] txWord, // word to send in the next frame
  output logic [15:0] rxWord, // last received word
  output logic frameOk, // last frame had exactly 16 bits
  output logic frameDone // one-cycle pulse after select rises
);
  logic sclkMetaQ, sclkSyncQ, sclkPrevQ; // clock synchroniser and history
  logic csMetaQ, csSyncQ, csPrevQ; // select synchroniser and history
  logic mosiMetaQ, mosiSyncQ; // data synchroniser
  logic [15:0] rxShQ; // receive shifter
  logic [15:0] txShQ; // transmit shifter
  logic [4:0] bitCntQ; // bits seen this frame, saturating
  wire logic selected = ~csSyncQ; // frame in progress
  wire logic sclkRise = sclkSyncQ & ~sclkPrevQ & selected;
  wire logic sclkFall = ~sclkSyncQ & sclkPrevQ & selected;
  wire logic csFall = ~csSyncQ & csPrevQ;
  wire logic csRise = csSyncQ & ~csPrevQ;

  // two flip-flops on every pin before use; no output on clock or select
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {sclkMetaQ, sclkSyncQ, sclkPrevQ} <= 3'h0;
      {csMetaQ, csSyncQ, csPrevQ} <= 3'h7;
      {mosiMetaQ, mosiSyncQ} <= 2'h0;
    end else begin
      {sclkMetaQ, sclkSyncQ, sclkPrevQ} <= {spiSclk, sclkMetaQ, sclkSyncQ};
      {csMetaQ, csSyncQ, csPrevQ} <= {chipSelectN, csMetaQ, csSyncQ};
      {mosiMetaQ, mosiSyncQ} <= {spiMosi, mosiMetaQ};
    end
  end

  // receive: capture on falling edges, count bits
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rxShQ <= 16'h0000;
      bitCntQ <= 5'h00;
    end else if (csFall) begin
      bitCntQ <= 5'h00;
    end else if (sclkFall) begin
      rxShQ <= {rxShQ[14:0], mosiSyncQ};
      if (bitCntQ != 5'h1f) bitCntQ <= bitCntQ + 5'h01;
    end
  end

  // transmit: load at frame start, launch one bit per rising edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      txShQ <= 16'h0000;
      spiMisoOut <= 1'b0;
    end else if (csFall) begin
      txShQ <= txWord;
      spiMisoOut <= 1'b0;
    end else if (sclkRise) begin
      spiMisoOut <= txShQ[15];
      txShQ <= {txShQ[14:0], 1'b0};
    end
  end

  // frame end: hand the word to the core
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rxWord <= 16'h0000;
      frameOk <= 1'b0;
      frameDone <= 1'b0;
    end else begin
      frameDone <= csRise;
      if (csRise) begin
        rxWord <= rxShQ;
        frameOk <= (bitCntQ == `RAC_FRAME_BITS);
      end
    end
  end

  assign spiMisoOe = selected;
endmodule

//--- rtl/rac_core.sv
// digital back end of the rotary angle sensor: conversion, gain loop,
// latency compensation, quadrature, commutation, pulse-width and serial port
// assumes sensX/sensY come from converter logic on ref_clk (no synchroniser),
// serial pins are asynchronous and pass two flip-flops in rac_spi_slave
`timescale 1ns/100ps
`include "rac_params.svh"
module rac_core
  import rac_pkg::*;
#(
  parameter int unsigned PON_CYCLES = `RAC_PON_CYCLES // power-on wait in cycles
) (
  input wire logic ref_clk, // core clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic signed [11:0] sensX, // cosine channel sample
  input wire logic signed [11:0] sensY, // sine channel sample
  input wire logic latencyCompDisable, // high: bypass compensation
  input wire logic noiseProfileSelect, // high: unfiltered, full temp range
  input wire logic incrementalResolutionSelect, // high: 11 bits, low: 10 bits
  input wire logic sharedPinPwmSelect, // high: shared pin carries pulse-width
  input wire logic spiSclk, // serial clock pin
  input wire logic chipSelectN, // serial select pin, active low
  input wire logic spiMosi, // serial data in pin
  output logic spiMisoOut, // serial data out
  output logic spiMisoOe, // serial data out enable
  output logic quadA, // incremental channel A
  output logic quadB, // incremental channel B
  output logic quadI, // index pulse
  output logic commU, // commutation phase U
  output logic commV, // commutation phase V
  output logic commWPwm, // phase W or pulse-width angle
  output logic [7:0] gainCode, // front-end gain setting
  output logic angleValid // high once power-on time has passed
);
  localparam logic signed [9:0] CompGain = 10'(`RAC_COMP_GAIN); // delay over sample period
  localparam logic [4:0] SampleLast = 5'(`RAC_SAMPLE_CYCLES - 1); // sample timer wrap
  localparam logic [3:0] StepLast = 4'(`RAC_STEP_CYCLES - 1); // step timer wrap
  localparam logic [12:0] PwmLast = 13'(`RAC_PWM_PERIOD - 1); // pulse-width frame wrap
  localparam logic [12:0] PwmHead = 13'(`RAC_PWM_HEAD); // fixed high lead-in

  // ---- sample pacing and conversion ----
  logic [4:0] sampleCntQ; // free-running sample timer
  logic sampleStartQ; // start pulse to the engine
  logic cordicDone; // engine result strobe
  rac_angle_t cordicAngle; // engine angle
  rac_angle_t cordicMagn; // engine magnitude

  // a new conversion every sample period, no request needed
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sampleCntQ <= 5'h00;
      sampleStartQ <= 1'b0;
    end else begin
      sampleCntQ <= (sampleCntQ == SampleLast) ? 5'h00 : sampleCntQ + 5'h01;
      sampleStartQ <= (sampleCntQ == SampleLast);
    end
  end

  rac_cordic rac_cordic_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(sampleStartQ),
    .sensX(sensX),
    .sensY(sensY),
    .done(cordicDone),
    .angle(cordicAngle),
    .magn(cordicMagn)
  );

  // ---- power-on wait ----
  logic [31:0] ponCntQ; // cycles since reset release
  wire logic ponReached = (ponCntQ >= PON_CYCLES); // wait over

  // hold outputs invalid until the power-on time has passed
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ponCntQ <= 32'h00000000;
      angleValid <= 1'b0;
    end else begin
      if (!ponReached) ponCntQ <= ponCntQ + 32'h00000001;
      angleValid <= ponReached;
    end
  end

  // ---- noise profile, angle history, compensation ----
  rac_angle_t rawPrevQ; // previous engine angle
  rac_angle_t angleRawQ; // uncompensated 14-bit angle
  rac_angle_t angleCompQ; // compensated 14-bit angle
  rac_angle_t magnQ; // latest magnitude
  wire rac_angle_t rawDelta = cordicAngle - rawPrevQ; // change since last sample
  wire rac_angle_t rawMid = rawPrevQ + {rawDelta[13], rawDelta[13:1]}; // two-sample mean
  wire rac_angle_t angleNext = noiseProfileSelect ? cordicAngle : rawMid;
  wire rac_angle_t speedEst = angleNext - angleRawQ;
  wire logic signed [23:0] corrWide = $signed(speedEst) * CompGain;
  wire rac_angle_t angleOut = latencyCompDisable ? angleRawQ : angleCompQ;

  // each result updates history, speed and the predicted angle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rawPrevQ <= 14'h0000;
      angleRawQ <= 14'h0000;
      angleCompQ <= 14'h0000;
      magnQ <= 14'h0000;
    end else if (cordicDone) begin
      rawPrevQ <= cordicAngle;
      angleRawQ <= angleNext;
      angleCompQ <= angleNext + corrWide[13:0];
      magnQ <= cordicMagn;
    end
  end

  // ---- gain control loop ----
  wire logic magnHigh = (cordicMagn > `RAC_AGC_TARGET + `RAC_AGC_HYST); // too strong
  wire logic magnLow = (cordicMagn < `RAC_AGC_TARGET - `RAC_AGC_HYST); // too weak

  // one gain step per result, saturating at both ends
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gainCode <= `RAC_AGC_RESET;
    end else if (cordicDone) begin
      if (magnHigh && gainCode != 8'h00) gainCode <= gainCode - 8'h01;
      else if (magnLow && gainCode != 8'hff) gainCode <= gainCode + 8'h01;
    end
  end

  // ---- quadrature interpolator ----
  logic [10:0] posQ; // emitted step position
  logic [3:0] stepCntQ; // step pacing timer
  wire logic res11 = incrementalResolutionSelect;
  wire logic [10:0] stepTarget = res11 ? angleOut[13:3] : {1'b0, angleOut[13:4]};
  wire logic [10:0] stepDiff = stepTarget - posQ; // distance to target
  wire logic stepBack = res11 ? stepDiff[10] : stepDiff[9]; // shorter way is backward
  wire logic stepNeed = res11 ? (stepDiff != 11'h000) : (stepDiff[9:0] != 10'h000); // not at target, on either side
  wire logic [10:0] posMask = res11 ? 11'h7ff : 11'h3ff; // wrap at one turn
  wire logic [10:0] posNext = (stepBack ? posQ - 11'h001 : posQ + 11'h001) & posMask; // one step
  wire logic stepSlot = (stepCntQ == StepLast); // a step may go now

  // walk one step per slot toward the target so no count is skipped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      posQ <= 11'h000;
      stepCntQ <= 4'h0;
    end else begin
      stepCntQ <= stepSlot ? 4'h0 : stepCntQ + 4'h1;
      if (stepSlot && stepNeed && angleValid) posQ <= posNext;
    end
  end

  // ---- commutation from the interpolated position ----
  wire logic [10:0] posFull = res11 ? posQ : {posQ[9:0], 1'b0}; // position on 11-bit scale
  wire logic [13:0] sectProd = 14'(posFull * 3'd6); // six sectors per turn
  wire logic [2:0] sector = sectProd[13:11]; // current sector 0..5
  wire logic [2:0] commNext = (sector == 3'd0) ? 3'b100 :
                              (sector == 3'd1) ? 3'b110 :
                              (sector == 3'd2) ? 3'b010 :
                              (sector == 3'd3) ? 3'b011 :
                              (sector == 3'd4) ? 3'b001 : 3'b101; // U V W pattern

  // ---- pulse-width encoder on the uncompensated angle ----
  logic [12:0] pwmCntQ; // position within the frame
  logic [11:0] pwmAngleQ; // angle latched for this frame
  wire logic pwmLevel = angleValid && (pwmCntQ < PwmHead + {1'b0, pwmAngleQ}); // high time
  wire logic sharedNext = sharedPinPwmSelect ? pwmLevel : commNext[0];

  // frame counter latches the raw angle at each frame start
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pwmCntQ <= 13'h0000;
      pwmAngleQ <= 12'h000;
    end else begin
      pwmCntQ <= (pwmCntQ == PwmLast) ? 13'h0000 : pwmCntQ + 13'h0001;
      if (pwmCntQ == PwmLast) pwmAngleQ <= angleRawQ[13:2];
    end
  end

  // registered pin drivers for incremental and commutation outputs
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {quadA, quadB, quadI} <= 3'b000;
      {commU, commV, commWPwm} <= 3'b000;
    end else begin
      quadA <= posQ[1] ^ posQ[0];
      quadB <= posQ[1];
      quadI <= angleValid && (posQ == 11'h000);
      commU <= commNext[2];
      commV <= commNext[1];
      commWPwm <= sharedNext;
    end
  end

  // ---- serial link ----
  logic [15:0] rxWord; // word of the frame just ended
  logic frameOk; // that frame had 16 bits
  logic frameDone; // frame end strobe
  logic [15:0] txWordQ; // answer for the next frame
  logic [2:0] errQ; // parity, invalid command, framing
  rac_link_t linkQ; // expecting command or write data
  logic [13:0] wrAddrQ; // address of a pending write

  rac_spi_slave rac_spi_slave_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .spiSclk(spiSclk),
    .chipSelectN(chipSelectN),
    .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut),
    .spiMisoOe(spiMisoOe),
    .txWord(txWordQ),
    .rxWord(rxWord),
    .frameOk(frameOk),
    .frameDone(frameDone)
  );

  wire logic parityBad = ^rxWord;
  wire logic frameBad = ~frameOk; // wrong bit count
  wire logic isData = (linkQ == RAC_LINK_DATA); // this frame is write data
  wire logic [13:0] cmdAddr = rxWord[13:0];
  wire logic cmdRead = rxWord[`RAC_FRM_RW];
  wire logic cmdGood = ~parityBad & ~frameBad; // command may execute
  wire logic [13:0] selAddr = isData ? wrAddrQ : cmdAddr; // register to report
  wire logic addrKnown = (selAddr == `RAC_ADDR_NOP) || (selAddr == `RAC_ADDR_ERRORS) ||
                         (selAddr >= `RAC_ADDR_DIAG); // mapped addresses
  wire logic writeBad = ~isData & cmdGood & ~cmdRead & (cmdAddr != `RAC_ADDR_NOP); // no writable target
  wire logic readBad = ~isData & cmdGood & cmdRead & ~addrKnown; // unmapped read
  wire logic [2:0] errNew = {parityBad, readBad | writeBad, frameBad}; // this frame's faults
  wire logic clearErr = ~isData & cmdGood & cmdRead & (cmdAddr == `RAC_ADDR_ERRORS); // read clears
  wire logic [7:0] diagBits = {4'h0, gainCode == 8'hff, gainCode == 8'h00, 1'b0, angleValid}; // diag flags
  wire logic [13:0] angleRawRd = angleValid ? angleRawQ : 14'h0000;
  wire logic [13:0] angleCompRd = angleValid ? angleOut : 14'h0000;
  wire logic [13:0] regData = (selAddr == `RAC_ADDR_ERRORS) ? {11'h000, errQ} :
                              (selAddr == `RAC_ADDR_DIAG) ? {diagBits[5:0], gainCode} :
                              (selAddr == `RAC_ADDR_MAGN) ? magnQ :
                              (selAddr == `RAC_ADDR_ANGLE_RAW) ? angleRawRd :
                              (selAddr == `RAC_ADDR_ANGLE_COMP) ? angleCompRd : 14'h0000;
  wire logic [13:0] respData = (isData | cmdGood) ? regData : 14'h0000; // corrupt command reads zero
  wire logic respErr = |(errQ | errNew); // error seen on the link
  wire logic [15:0] respWord = {^{respErr, respData}, respErr, respData};

  // frame end: check, execute, and capture the answer for the next frame
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      txWordQ <= 16'h0000;
      errQ <= 3'b000;
      linkQ <= RAC_LINK_CMD;
      wrAddrQ <= 14'h0000;
    end else if (frameDone) begin
      txWordQ <= respWord;
      errQ <= clearErr ? errNew : (errQ | errNew); // new faults survive a clearing read
      if (isData) begin
        linkQ <= RAC_LINK_CMD; // write data taken, nothing writable here
      end else if (cmdGood && !cmdRead) begin
        linkQ <= RAC_LINK_DATA;
        wrAddrQ <= cmdAddr;
      end
    end
  end
endmodule

//--- tb/rac_core_properties.sv
// port-level checker for rac_core
// assumes it is bound onto every rac_core instance
`timescale 1ns/100ps
module rac_core_properties #(
  parameter int unsigned PON_CYCLES = 50 // power-on wait in cycles
) (
  input wire logic ref_clk, // core clock
  input wire logic rstn, // sync reset, active low
  input wire logic chipSelectN, // select pin
  input wire logic spiMisoOe, // data out enable
  input wire logic sharedPinPwmSelect, // shared pin mode
  input wire logic quadA, // channel a
  input wire logic quadB, // channel b
  input wire logic quadI, // index
  input wire logic commU, // phase u
  input wire logic commV, // phase v
  input wire logic commWPwm, // phase w or pulse-width
  input wire logic [7:0] gainCode, // gain setting
  input wire logic angleValid // power-on done
);
  logic [31:0] upCnt_q; // cycles since reset release, saturating
  // counts up only until past the power-on figure
  always_ff @(posedge ref_clk) begin
    if (!rstn) upCnt_q <= 32'h0;
    else if (upCnt_q <= PON_CYCLES) upCnt_q <= upCnt_q + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  oe_off_a: assert property (chipSelectN [*5] |-> !spiMisoOe)
    else $error("slave-out driven while deselected");
  oe_on_a: assert property (!chipSelectN [*5] |-> spiMisoOe)
    else $error("slave-out not driven while selected");
  valid_wait_a: assert property (angleValid |-> upCnt_q >= PON_CYCLES)
    else $error("angle valid too early");
  valid_hold_a: assert property (angleValid |=> angleValid)
    else $error("angle valid dropped");
  quad_hold_a: assert property (!angleValid |-> !quadA && !quadB && !quadI)
    else $error("quadrature moved before valid");
  quad_step_a: assert property ($changed({quadA, quadB}) |=> $stable({quadA, quadB}))
    else $error("quadrature stepped too fast");
  quad_gray_a: assert property (!($changed(quadA) && $changed(quadB)))
    else $error("both quadrature channels changed");
  index_zero_a: assert property (quadI |-> !quadA && !quadB)
    else $error("index away from position zero");
  comm_code_a: assert property (angleValid && $past(angleValid) && !sharedPinPwmSelect
    && !$past(sharedPinPwmSelect) |-> {commU, commV, commWPwm} inside {3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5})
    else $error("illegal commutation code");
  gain_reset_a: assert property ($rose(rstn) |-> gainCode == 8'h80)
    else $error("gain not at reset value");
  cover property ($fell(chipSelectN));
  cover property ($rose(angleValid));
  cover property (sharedPinPwmSelect && $rose(commWPwm));
endmodule
bind rac_core rac_core_properties #(.PON_CYCLES(PON_CYCLES)) rac_core_properties_i (.ref_clk(ref_clk),
  .rstn(rstn), .chipSelectN(chipSelectN), .spiMisoOe(spiMisoOe), .sharedPinPwmSelect(sharedPinPwmSelect),
  .quadA(quadA), .quadB(quadB), .quadI(quadI), .commU(commU), .commV(commV), .commWPwm(commWPwm),
  .gainCode(gainCode), .angleValid(angleValid));

//--- tb/rac_spi_host.sv
// host-side serial master model, mode 1, 125 ns bit period
// assumes slave-out settles within half a bit after each rise
`timescale 1ns/100ps
module rac_spi_host (
  output logic spiSclk, // serial clock to device
  output logic chipSelectN, // select, active low
  output logic spiMosi, // data to device
  input wire logic spiMisoOut // data from device, as seen on the wire
);
  // idle: clock low, deselected
  initial begin
    spiSclk = 1'b0;
    chipSelectN = 1'b1;
    spiMosi = 1'b0;
  end
  // one frame of nb bits, msb first, answer taken at each fall
  task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
    rx = 16'h0;
    chipSelectN = 1'b0; // select falls with clock low
    #350;
    for (int i = 15; i > 15 - nb; i--) begin
      spiSclk = 1'b1; // launch edge, 8 MHz rate
      spiMosi = tx[i]; // msb first
      #62.5;
      spiSclk = 1'b0; // device captures here
      rx = {rx[14:0], spiMisoOut};
      #62.5;
    end
    chipSelectN = 1'b1; // frame end starts execution
    spiMosi = ~spiMosi; // released line shows no stale value
    #400;
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench for rac_core: serial reads, errors, phases, pulse-width
// assumes rac_spi_host as serial master and a static field at a quarter turn
`timescale 1ns/100ps
module tb;
  logic ref_clk, rstn, latencyCompDisable, noiseProfileSelect, incrementalResolutionSelect, sharedPinPwmSelect;
  logic signed [11:0] sensX, sensY; // field vector samples
  logic spiSclk, chipSelectN, spiMosi, spiMisoOut, spiMisoOe, quadA, quadB, quadI, commU, commV, commWPwm;
  logic angleValid; // power-on done
  logic [7:0] gainCode; // gain setting
  logic [15:0] ans; // last answer word
  int err_total = 0; // mismatches
  int num_checks = 0; // comparisons
  int n; // wait counter
  rac_core #(.PON_CYCLES(50)) rac_core_i (.ref_clk(ref_clk), .rstn(rstn), .sensX(sensX), .sensY(sensY),
    .latencyCompDisable(latencyCompDisable), .noiseProfileSelect(noiseProfileSelect),
    .incrementalResolutionSelect(incrementalResolutionSelect), .sharedPinPwmSelect(sharedPinPwmSelect),
    .spiSclk(spiSclk), .chipSelectN(chipSelectN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
    .spiMisoOe(spiMisoOe), .quadA(quadA), .quadB(quadB), .quadI(quadI), .commU(commU), .commV(commV),
    .commWPwm(commWPwm), .gainCode(gainCode), .angleValid(angleValid));
  // released slave-out toggles so a stale bit cannot pass
  rac_spi_host rac_spi_host_i (.spiSclk(spiSclk), .chipSelectN(chipSelectN), .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOe ? spiMisoOut : ref_clk));
  // 100 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // compare within a tolerance, unknowns never match
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp, input int tol);
    int d;
    d = int'(got) - int'(exp);
    num_checks++;
    if (got !== exp && ($isunknown(got) || d > tol || d < -tol)) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // read command word with even parity over the whole word
  function automatic logic [15:0] cmdw(input logic [13:0] a);
    return {^{1'b1, a}, 1'b1, a};
  endfunction
  // one frame, answer parity checked
  task automatic xf(input logic [15:0] tx, input int nb);
    rac_spi_host_i.xfer(tx, nb, ans);
    check("parity", {15'h0, ^ans}, 16'h0, 0);
  endtask
  // read: command frame, then a no-op frame carries the answer
  task automatic rd(input logic [13:0] a);
    xf(cmdw(a), 16);
    xf(cmdw(14'h0000), 16);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    sensX = 12'sd0;
    sensY = 12'sd1000;
    {latencyCompDisable, noiseProfileSelect, incrementalResolutionSelect, sharedPinPwmSelect} = 4'h0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    check("early valid", {15'h0, angleValid}, 16'h0, 0);
    check("gain reset", {8'h0, gainCode}, 16'h0080, 0);
    for (n = 0; n < 200 && angleValid !== 1'b1; n++) @(negedge ref_clk);
    check("valid", {15'h0, angleValid}, 16'h1, 0);
    // both angle registers, each under two of the eight switch settings
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      latencyCompDisable <= i[0];
      noiseProfileSelect <= i[1] ^ i[0];
      incrementalResolutionSelect <= i[1];
      repeat (4 * 22) @(posedge ref_clk);
      rd(i[1] ? 14'h3fff : 14'h3ffe);
      check("angle", {2'h0, ans[13:0]}, 16'h1000, 4);
      check("error flag", {15'h0, ans[14]}, 16'h0, 0);
    end
    rd(14'h3ffd);
    check("magnitude", {2'h0, ans[13:0]}, 16'd1647, 8);
    // weak field has driven the gain to its top: low-field flag and loops-done set
    rd(14'h3ffc);
    check("diag", {2'h0, ans[13:0]}, 16'h09ff, 0);
    // bad parity, unmapped read, short frame, write to a read-only address; then error register
    for (int i = 0; i < 4; i++) begin
      xf(i == 3 ? cmdw(14'h3ffe) ^ 16'hc000 : i == 0 ? cmdw(14'h3ffe) ^ 16'h8000 :
        cmdw(i == 1 ? 14'h0003 : 14'h3ffe), 16 - (i == 2));
      // a write command is followed by its data frame, which shifts out the old content
      if (i == 3) begin
        xf(16'h0000, 16);
        check("old content", {2'h0, ans[13:0]}, 16'h1000, 4);
      end
      xf(cmdw(14'h0001), 16);
      check("error flag", {15'h0, ans[14]}, 16'h1, 0);
      xf(cmdw(14'h0000), 16);
      check("error bits", {2'h0, ans[13:0]}, i == 3 ? 16'h2 : 16'h4 >> i, 0);
    end
    check("phases", {13'h0, commU, commV, commWPwm}, 16'h0006, 0);
    @(posedge ref_clk);
    sharedPinPwmSelect <= 1'b1;
    for (n = 0; n < 9000 && commWPwm !== 1'b0; n++) @(negedge ref_clk);
    for (n = 0; n < 9000 && commWPwm !== 1'b1; n++) @(negedge ref_clk);
    for (n = 0; n < 5000 && commWPwm === 1'b1; n++) @(negedge ref_clk);
    check("pulse width", n[15:0], 16'd16 + (16'h1000 >> 2), 2);
    give_verdict();
  end
endmodule
